// File: bench/nand_flash_model.sv
// Behavioural flash facing the host: commands, busy, status and ID bytes.
// Assumes host strobes change on clk_sys; ready/busy is open drain.
`timescale 1ns/10ps
module nand_flash_model #(
	parameter logic [7:0] MAKER = 8'h3a, // Arbitrary value.
	parameter logic [7:0] DEVICE = 8'h5c // Arbitrary value.
) (
	input wire logic clk_sys,
	input wire logic [7:0] io_out,
	input wire logic cle,
	input wire logic ale,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	output logic [7:0] dq,
	output logic dq_oe,
	output logic rb_low
);
	logic [7:0] log_q[$];
	int op_len = 20;
	int busy = 0;
	int nload = 0;
	bit fail_next = 1'b0;
	bit stuck = 1'b0;
	bit resetting = 1'b0;
	bit fail = 1'b0;
	bit in_id = 1'b0;
	bit id_ix = 1'b0;
	logic [1:0] ptr = 2'h0;
	logic [7:0] op = 8'h00;
	logic we_q = 1'b1;
	logic re_q = 1'b1;
	assign rb_low = busy != 0;
	assign dq_oe = !ce_n && !re_n;
	assign dq = in_id ? (id_ix ? DEVICE : MAKER)
		: {wp_n, busy == 0, 5'h00, fail};
	task start;
		fail = fail_next;
		busy <= op_len;
		op = 8'h00;
		if (ptr == 2'h1)
			ptr = 2'h0;
	endtask : start
	task flush;
		busy <= 20;
		resetting = 1'b1;
		fail = 1'b0;
		in_id = 1'b0;
		ptr = 2'h0;
		op = 8'h00;
	endtask : flush
	task command(input logic [7:0] c);
		if (busy != 0)
		begin
			if (c == 8'h70)
				in_id = 1'b0;
			else if (c == 8'hff && !resetting)
				flush();
		end
		else
		case (c)
			8'h80:
			begin
				op = c;
				nload = 0;
			end
			8'h60:
				op = c;
			8'h10:
				if (op == 8'h80 && nload > 0 && wp_n)
					start();
			8'hd0:
				if (op == 8'h60 && wp_n)
					start();
			8'h90:
			begin
				in_id = 1'b1;
				id_ix = 1'b0;
			end
			8'hff:
				flush();
			8'h01:
				ptr = 2'h1;
			default:
				in_id = 1'b0;
		endcase
	endtask : command
	always @(posedge clk_sys)
	begin
		we_q <= we_n;
		re_q <= re_n;
		if (busy == 0)
			resetting = 1'b0;
		else if (!(resetting && stuck))
			busy <= busy - 1;
		if (re_n && !re_q && in_id)
			id_ix = 1'b1;
		if (we_n && !we_q && !ce_n)
		begin
			log_q.push_back(io_out);
			if (cle)
				command(io_out);
			else if (!ale)
				nload++;
		end
	end
endmodule : nand_flash_model

// File: bench/nand_host_monitor.sv
// Checker of the flash-side sequencing of nand_host, bound to its ports.
// Assumes rb_n is the resolved ready/busy wire that the host sees.
`timescale 1ns/10ps
module nand_host_monitor (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic cle,
	input wire logic ale,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic rb_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	a_reset_quiet: assert property (disable iff (1'b0)
		!resetn |=> ce_n && we_n && re_n && !io_oe && !wp_n)
		else $error("bus not idle after reset");
	a_we_single: assert property ($fell(we_n) |=> we_n && re_n)
		else $error("write strobe longer than one cycle");
	a_data_held: assert property ($fell(we_n) |->
		io_oe && !ce_n && $stable(io_out) ##1 io_oe && $stable(io_out))
		else $error("byte not held around write strobe");
	a_busy_commands: assert property (
		!rb_n && !we_n && cle |-> io_out == 8'h70 || io_out == 8'hff)
		else $error("command other than status or reset while busy");
	a_protect_blocks: assert property (
		!wp_n && !we_n && cle |-> io_out != 8'h80 && io_out != 8'h60)
		else $error("program or erase sent while protected");
	a_read_released: assert property (
		!re_n |-> !io_oe && !ce_n && !cle && !ale && we_n)
		else $error("host drives the bus during a read");
	a_turnaround: assert property (
		$fell(re_n) |-> $past(we_n) && $past(we_n, 2) && $past(we_n, 3))
		else $error("read strobe too soon after write strobe");
	a_confirm_wait: assert property (
		$rose(we_n) && cle && (io_out == 8'h10 || io_out == 8'hd0)
		|=> (we_n && re_n)[*3])
		else $error("strobe right after confirm command");
	a_wp_follows: assert property (
		reg_wr && reg_addr == nand_host_pkg::REG_CFG
		|=> ##1 wp_n == $past(reg_wdata[0], 2))
		else $error("write protect does not follow config");
endmodule : nand_host_monitor

bind nand_host nand_host_monitor mon (.clk_sys, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .io_out, .io_oe, .cle, .ale, .ce_n, .we_n, .re_n,
	.wp_n, .rb_n);

// File: bench/tb_nand_host.sv
// Self-checking bench of nand_host against the behavioural flash model.
// Assumes the checker and the flash model are compiled before this file.
`timescale 1ns/10ps
module tb_nand_host;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, st;
	logic [7:0] io_in, io_out, dq;
	logic io_oe, cle, ale, ce_n, we_n, re_n, wp_n, rb_n, dq_oe, rb_low;
	logic pat = 1'b0;
	logic [7:0] exp_q[$];
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	assign io_in = io_oe ? io_out : (dq_oe ? dq : {8{pat}});
	assign rb_n = !rb_low;
	nand_host #(.BUSY_LIMIT(50)) dut (.clk_sys, .resetn, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_in, .io_out, .io_oe,
		.cle, .ale, .ce_n, .we_n, .re_n, .wp_n, .rb_n);
	nand_flash_model mdl (.clk_sys, .io_out, .cle, .ale, .ce_n, .we_n,
		.re_n, .wp_n, .dq, .dq_oe, .rb_low);
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		pat <= ~pat;
		cycles++;
		if (cycles == 40000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 st = reg_rdata;
	endtask : rd
	task ctrl(input logic [2:0] op);
		wr(nand_host_pkg::REG_CTRL, {29'h0, op});
	endtask : ctrl
	task wait_idle;
		int k;
		k = 0;
		rd(nand_host_pkg::REG_STAT);
		while (st[8] !== 1'b0 && k < 500)
		begin
			rd(nand_host_pkg::REG_STAT);
			k++;
		end
		chk("busy", 32'h0, {31'h0, st[8]});
		rd(nand_host_pkg::REG_STAT);
	endtask : wait_idle
	task chk_log;
		chk("log size", exp_q.size(), mdl.log_q.size());
		foreach (exp_q[i])
			chk("log byte", {24'h0, exp_q[i]}, {24'h0, mdl.log_q[i]});
		mdl.log_q.delete();
	endtask : chk_log
	task prog(input logic [23:0] a, input int n);
		wr(nand_host_pkg::REG_ADDR, {8'h0, a});
		for (int i = 0; i < n; i++)
			wr(nand_host_pkg::REG_DATA, 32'h5a + i);
		ctrl(nand_host_pkg::OP_PROGRAM);
		wait_idle();
	endtask : prog
	task t_reset;
		rd(nand_host_pkg::REG_STAT);
		chk("status word", 32'hc0, st);
		chk("wp_n", 32'h0, {31'h0, wp_n});
		rd(4'hf);
		chk("unmapped", 32'h0, st);
		wr(nand_host_pkg::REG_CFG, 32'h1);
		ctrl(nand_host_pkg::OP_PROGRAM);
		rd(nand_host_pkg::REG_STAT);
		chk("empty refused", 32'h1, {31'h0, st[9]});
		wr(nand_host_pkg::REG_CFG, 32'h0);
		ctrl(nand_host_pkg::OP_ERASE);
		rd(nand_host_pkg::REG_STAT);
		chk("protect refused", 32'h1, {31'h0, st[9]});
		chk("bus silent", 32'h0, mdl.log_q.size());
		wr(nand_host_pkg::REG_CFG, 32'h1);
		$display("end reset and refusals");
	endtask : t_reset
	task t_program_erase(input bit bad);
		mdl.fail_next = bad;
		prog(24'h0a0b0c, 2);
		exp_q = '{8'h80, 8'h0c, 8'h0b, 8'h0a, 8'h5a, 8'h5b, 8'h10, 8'h70};
		chk_log();
		chk("prog status", {24'h0, 7'h60, bad}, {24'h0, st[7:0]});
		wr(nand_host_pkg::REG_ADDR, 32'h5a3c77);
		ctrl(nand_host_pkg::OP_ERASE);
		wait_idle();
		exp_q = '{8'h60, 8'h30, 8'h5a, 8'hd0, 8'h70};
		chk_log();
		chk("erase status", {24'h0, 7'h60, bad}, {24'h0, st[7:0]});
		mdl.fail_next = 1'b0;
		$display("end program and erase");
	endtask : t_program_erase
	task t_partial;
		for (int i = 0; i < 11; i++)
		begin
			prog(24'h020000, 1);
			chk("partial refused", {31'h0, i == 10}, {31'h0, st[9]});
		end
		chk("partial count", 32'ha, {28'h0, st[14:11]});
		wr(nand_host_pkg::REG_ADDR, 32'h020000);
		ctrl(nand_host_pkg::OP_ERASE);
		wait_idle();
		prog(24'h020000, 0);
		chk("after erase", 32'h0, {31'h0, st[9]});
		mdl.log_q.delete();
		$display("end partial programs");
	endtask : t_partial
	task t_modes;
		ctrl(nand_host_pkg::OP_PTR_B);
		wait_idle();
		chk("pointer b", 32'h1, {30'h0, st[16:15]});
		prog(24'h000180, 1);
		chk("pointer back", 32'h0, {30'h0, st[16:15]});
		mdl.log_q.delete();
		ctrl(nand_host_pkg::OP_ID);
		wait_idle();
		exp_q = '{8'h90, 8'h00};
		chk_log();
		rd(nand_host_pkg::REG_ID);
		chk("id", {16'h0, mdl.DEVICE, mdl.MAKER}, {16'h0, st[15:0]});
		ctrl(nand_host_pkg::OP_STATUS);
		wait_idle();
		exp_q = '{8'h70};
		chk_log();
		chk("status mode", 32'h1, {31'h0, st[17]});
		ctrl(nand_host_pkg::OP_PTR_C);
		wait_idle();
		chk("pointer c", 32'h2, {30'h0, st[16:15]});
		chk("mode left", 32'h0, {31'h0, st[17]});
		ctrl(nand_host_pkg::OP_PTR_A);
		wait_idle();
		chk("pointer a", 32'h0, {30'h0, st[16:15]});
		exp_q = '{8'h50, 8'h00};
		chk_log();
		$display("end pointer, id and status");
	endtask : t_modes
	task t_abort;
		mdl.op_len = 45;
		prog(24'h030000, 0);
		wr(nand_host_pkg::REG_DATA, 32'h00);
		ctrl(nand_host_pkg::OP_PROGRAM);
		repeat (28) @(posedge clk_sys);
		ctrl(nand_host_pkg::OP_STATUS);
		rd(nand_host_pkg::REG_STAT);
		chk("busy refused", 32'h1, {31'h0, st[9]});
		ctrl(nand_host_pkg::OP_RESET);
		wait_idle();
		chk("abort byte", 32'hff, {24'h0, mdl.log_q[$]});
		chk("abort status", 32'hc0, {24'h0, st[7:0]});
		chk("no timeout", 32'h0, {31'h0, st[10]});
		mdl.op_len = 20;
		mdl.stuck = 1'b1;
		ctrl(nand_host_pkg::OP_RESET);
		wait_idle();
		chk("timeout", 32'h1, {31'h0, st[10]});
		mdl.stuck = 1'b0;
		repeat (30) @(posedge clk_sys);
		$display("end abort and timeout");
	endtask : t_abort
	initial
	begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_program_erase(1'b0);
		t_program_erase(1'b1);
		t_partial();
		t_modes();
		t_abort();
		tally_and_finish();
	end
endmodule : tb_nand_host

// File: core/nand_host.sv
// Host sequencer for a byte-wide NAND flash: program, erase, status, ID,
// pointer and reset commands, driven from a small software register port.
// Assumes bus inputs are synchronous to clk_sys and ready/busy is pulled up.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module nand_host #(
	parameter int PAGE_DEPTH = nand_host_pkg::PAGE_BYTES,
	parameter int BUSY_LIMIT = nand_host_pkg::RST_CYCLES,
	parameter int PP_MAX = nand_host_pkg::PARTIAL_MAX
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic cle,
	output logic ale,
	output logic ce_n,
	output logic we_n,
	output logic re_n,
	output logic wp_n,
	input wire logic rb_n
);
	if (PAGE_DEPTH < 1 || PAGE_DEPTH > 1024)
		$error("nand_host: page depth must be 1 to 1024");
	if (BUSY_LIMIT < 1 || BUSY_LIMIT > 16383)
		$error("nand_host: busy limit must be 1 to 16383");
	if (PP_MAX < 1 || PP_MAX > 15)
		$error("nand_host: partial program limit must be 1 to 15");

	nand_host_pkg::state_type state_q, state_d;
	logic [1:0] ph_q, ph_d;
	logic [2:0] op_q, op_d;
	logic [7:0] cmd_q, cmd_d;
	logic [13:0] cnt_q, cnt_d;
	logic [1:0] aidx_q, aidx_d;
	logic [9:0] didx_q, didx_d;
	logic ridx_q, ridx_d;
	logic [7:0] io_out_q, io_out_d;
	logic io_oe_q, io_oe_d;
	logic cle_q, cle_d;
	logic ale_q, ale_d;
	logic we_n_q, we_n_d;
	logic re_n_q, re_n_d;
	logic ce_n_q, ce_n_d;
	logic [7:0] status_byte_q, status_byte_d;
	logic [7:0] maker_q, maker_d;
	logic [7:0] device_q, device_d;
	logic refused_q, refused_d;
	logic timeout_q, timeout_d;
	logic [15:0] page_q, page_d;
	logic [3:0] pp_cnt_q, pp_cnt_d;
	logic [1:0] ptr_q, ptr_d;
	logic stat_mode_q, stat_mode_d;
	logic wp_en_q, wp_en_d;
	logic [23:0] addr_q, addr_d;
	logic [9:0] wr_ptr_q, wr_ptr_d;
	logic [31:0] rdata_q, rdata_d;

	logic go;
	logic [2:0] go_op;
	logic abort;
	logic launch;
	logic same_page;
	logic [7:0] wbyte;
	logic [7:0] buf_rdata;
	logic buf_we;

	assign go = reg_wr && reg_addr == nand_host_pkg::REG_CTRL;
	assign go_op = reg_wdata[2:0];
	assign same_page = addr_q[23:8] == page_q;

	page_buffer #(
		.WIDTH(8),
		.DEPTH(PAGE_DEPTH),
		.AW(10)
	) u_buf (
		.clk_sys(clk_sys),
		.wr_en(buf_we),
		.wr_addr(wr_ptr_q),
		.wr_data(reg_wdata[7:0]),
		.rd_addr(didx_q),
		.rd_data(buf_rdata)
	);

	// Byte presented in the bus write states.
	always_comb
	begin
		wbyte = cmd_q;
		if (state_q == nand_host_pkg::ST_DATA)
			wbyte = buf_rdata;
		else if (state_q == nand_host_pkg::ST_ADDR)
		begin
			if (op_q == nand_host_pkg::OP_ID)
				wbyte = nand_host_pkg::ID_ADDR;
			else if (aidx_q == 2'h0)
				wbyte = addr_q[7:0];
			else if (aidx_q == 2'h1 && op_q == nand_host_pkg::OP_ERASE)
				wbyte = {addr_q[15:12], 4'h0};
			else if (aidx_q == 2'h1)
				wbyte = addr_q[15:8];
			else
				wbyte = addr_q[23:16];
		end
	end

	always_comb
	begin
		state_d = state_q;
		ph_d = ph_q;
		op_d = op_q;
		cmd_d = cmd_q;
		cnt_d = cnt_q;
		aidx_d = aidx_q;
		didx_d = didx_q;
		ridx_d = ridx_q;
		io_out_d = io_out_q;
		io_oe_d = io_oe_q;
		cle_d = cle_q;
		ale_d = ale_q;
		we_n_d = we_n_q;
		re_n_d = re_n_q;
		ce_n_d = ce_n_q;
		status_byte_d = status_byte_q;
		maker_d = maker_q;
		device_d = device_q;
		refused_d = refused_q;
		timeout_d = timeout_q;
		page_d = page_q;
		pp_cnt_d = pp_cnt_q;
		ptr_d = ptr_q;
		stat_mode_d = stat_mode_q;
		launch = 1'b0;
		abort = go && go_op == nand_host_pkg::OP_RESET
			&& op_q != nand_host_pkg::OP_RESET
			&& state_q == nand_host_pkg::ST_BUSY;
		// Orders arriving mid-sequence are dropped, except a reset abort.
		if (go && state_q != nand_host_pkg::ST_IDLE && !abort)
			refused_d = 1'b1;
		// Each bus write is setup, strobe low, strobe high: 150 ns a byte.
		if (state_q == nand_host_pkg::ST_CMD
			|| state_q == nand_host_pkg::ST_ADDR
			|| state_q == nand_host_pkg::ST_DATA)
		begin
			if (ph_q == 2'h0)
			begin
				io_out_d = wbyte;
				io_oe_d = 1'b1;
				cle_d = state_q == nand_host_pkg::ST_CMD;
				ale_d = state_q == nand_host_pkg::ST_ADDR;
				ph_d = 2'h1;
			end
			else if (ph_q == 2'h1)
			begin
				we_n_d = 1'b0;
				ph_d = 2'h2;
				if (state_q == nand_host_pkg::ST_DATA)
					didx_d = didx_q + 10'h001;
			end
			else
			begin
				we_n_d = 1'b1;
				ph_d = 2'h0;
			end
		end
		else
		begin
			cle_d = 1'b0;
			ale_d = 1'b0;
			io_oe_d = 1'b0;
		end

		unique case (state_q)
		nand_host_pkg::ST_IDLE:
		begin
			ce_n_d = 1'b1;
			if (go)
			begin
				if ((go_op == nand_host_pkg::OP_PROGRAM
					|| go_op == nand_host_pkg::OP_ERASE) && !wp_en_q)
					refused_d = 1'b1;
				else if (go_op == nand_host_pkg::OP_PROGRAM
					&& wr_ptr_q == 10'h000)
					refused_d = 1'b1;
				else if (go_op == nand_host_pkg::OP_PROGRAM && same_page
					&& pp_cnt_q == 4'(PP_MAX))
					refused_d = 1'b1;
				else
				begin
					refused_d = 1'b0;
					timeout_d = 1'b0;
					op_d = go_op;
					ce_n_d = 1'b0;
					ph_d = 2'h0;
					aidx_d = 2'h0;
					didx_d = 10'h000;
					ridx_d = 1'b0;
					cnt_d = 14'h0000;
					state_d = nand_host_pkg::ST_CMD;
					unique case (go_op)
					nand_host_pkg::OP_RESET: cmd_d = nand_host_pkg::CMD_RESET;
					nand_host_pkg::OP_PROGRAM: cmd_d = nand_host_pkg::CMD_PROG;
					nand_host_pkg::OP_ERASE: cmd_d = nand_host_pkg::CMD_ERASE;
					nand_host_pkg::OP_STATUS: cmd_d = nand_host_pkg::CMD_STATUS;
					nand_host_pkg::OP_ID: cmd_d = nand_host_pkg::CMD_ID;
					nand_host_pkg::OP_PTR_A: cmd_d = nand_host_pkg::CMD_READ_A;
					nand_host_pkg::OP_PTR_B: cmd_d = nand_host_pkg::CMD_READ_B;
					nand_host_pkg::OP_PTR_C: cmd_d = nand_host_pkg::CMD_READ_C;
					endcase
				end
			end
		end
		nand_host_pkg::ST_CMD:
		begin
			if (ph_q == 2'h2)
			begin
				unique case (cmd_q)
				nand_host_pkg::CMD_PROG, nand_host_pkg::CMD_ERASE,
				nand_host_pkg::CMD_ID:
				begin
					state_d = nand_host_pkg::ST_ADDR;
					aidx_d = (op_q == nand_host_pkg::OP_ERASE) ? 2'h1 : 2'h0;
				end
				nand_host_pkg::CMD_STATUS:
					state_d = nand_host_pkg::ST_GAP;
				nand_host_pkg::CMD_PROG_GO, nand_host_pkg::CMD_ERASE_GO,
				nand_host_pkg::CMD_RESET:
					state_d = nand_host_pkg::ST_WAIT;
				default:
				begin
					// Pointer commands also leave status mode.
					state_d = nand_host_pkg::ST_IDLE;
					stat_mode_d = 1'b0;
					ptr_d = (cmd_q == nand_host_pkg::CMD_READ_B)
						? nand_host_pkg::PTR_B
						: (cmd_q == nand_host_pkg::CMD_READ_C)
						? nand_host_pkg::PTR_C : nand_host_pkg::PTR_A;
				end
				endcase
			end
		end
		nand_host_pkg::ST_ADDR:
		begin
			if (ph_q == 2'h2)
			begin
				if (op_q == nand_host_pkg::OP_ID)
					state_d = nand_host_pkg::ST_GAP;
				else if (aidx_q != 2'h2)
					aidx_d = aidx_q + 2'h1;
				else if (op_q == nand_host_pkg::OP_PROGRAM)
					state_d = nand_host_pkg::ST_DATA;
				else
				begin
					state_d = nand_host_pkg::ST_CMD;
					cmd_d = nand_host_pkg::CMD_ERASE_GO;
					if (addr_q[23:12] == page_q[15:4])
						pp_cnt_d = 4'h0;
				end
			end
		end
		nand_host_pkg::ST_DATA:
		begin
			// Only the loaded byte count is sent from the column address.
			if (ph_q == 2'h2 && didx_q == wr_ptr_q)
			begin
				state_d = nand_host_pkg::ST_CMD;
				cmd_d = nand_host_pkg::CMD_PROG_GO;
				launch = 1'b1;
				page_d = addr_q[23:8];
				pp_cnt_d = same_page ? pp_cnt_q + 4'h1 : 4'h1;
			end
		end
		nand_host_pkg::ST_WAIT:
		begin
			// Ready/busy may take tWB to fall after the last strobe.
			if (cnt_q == 14'(nand_host_pkg::WB_CYCLES - 1))
			begin
				cnt_d = 14'h0000;
				state_d = nand_host_pkg::ST_BUSY;
			end
			else
				cnt_d = cnt_q + 14'h0001;
		end
		nand_host_pkg::ST_BUSY:
		begin
			cnt_d = cnt_q + 14'h0001;
			if (abort)
			begin
				op_d = nand_host_pkg::OP_RESET;
				cmd_d = nand_host_pkg::CMD_RESET;
				ph_d = 2'h0;
				cnt_d = 14'h0000;
				state_d = nand_host_pkg::ST_CMD;
			end
			else if (rb_n)
			begin
				cnt_d = 14'h0000;
				if (op_q == nand_host_pkg::OP_RESET)
				begin
					status_byte_d = nand_host_pkg::STATUS_RESET;
					status_byte_d[nand_host_pkg::UNPROTECTED_BIT] = wp_en_q;
					ptr_d = nand_host_pkg::PTR_A;
					stat_mode_d = 1'b0;
					state_d = nand_host_pkg::ST_IDLE;
				end
				else
				begin
					cmd_d = nand_host_pkg::CMD_STATUS;
					ph_d = 2'h0;
					state_d = nand_host_pkg::ST_CMD;
				end
			end
			else if (op_q == nand_host_pkg::OP_RESET
				&& cnt_q == 14'(BUSY_LIMIT - 1))
			begin
				timeout_d = 1'b1;
				state_d = nand_host_pkg::ST_IDLE;
			end
		end
		nand_host_pkg::ST_GAP:
		begin
			if (cnt_q == 14'(nand_host_pkg::WHR_CYCLES - 1))
			begin
				cnt_d = 14'h0000;
				ph_d = 2'h0;
				state_d = nand_host_pkg::ST_READ;
			end
			else
				cnt_d = cnt_q + 14'h0001;
		end
		nand_host_pkg::ST_READ:
		begin
			if (ph_q == 2'h0)
			begin
				re_n_d = 1'b0;
				ph_d = 2'h1;
			end
			else if (ph_q == 2'h1)
			begin
				re_n_d = 1'b1;
				ph_d = 2'h2;
				if (op_q != nand_host_pkg::OP_ID)
					status_byte_d = io_in;
				else if (!ridx_q)
					maker_d = io_in;
				else
					device_d = io_in;
			end
			else
			begin
				ph_d = 2'h0;
				if (op_q == nand_host_pkg::OP_ID && !ridx_q)
					ridx_d = 1'b1;
				else
				begin
					state_d = nand_host_pkg::ST_IDLE;
					stat_mode_d = op_q != nand_host_pkg::OP_ID;
					if (op_q != nand_host_pkg::OP_STATUS
						&& op_q != nand_host_pkg::OP_ID
						&& ptr_q == nand_host_pkg::PTR_B)
						ptr_d = nand_host_pkg::PTR_A;
				end
			end
		end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_q <= nand_host_pkg::ST_IDLE;
			ph_q <= 2'h0;
			op_q <= nand_host_pkg::OP_STATUS;
			cmd_q <= 8'h00;
			cnt_q <= 14'h0000;
			aidx_q <= 2'h0;
			didx_q <= 10'h000;
			ridx_q <= 1'b0;
			io_out_q <= 8'h00;
			io_oe_q <= 1'b0;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			ce_n_q <= 1'b1;
			status_byte_q <= nand_host_pkg::STATUS_RESET;
			maker_q <= 8'h00;
			device_q <= 8'h00;
			refused_q <= 1'b0;
			timeout_q <= 1'b0;
			page_q <= 16'h0000;
			pp_cnt_q <= 4'h0;
			ptr_q <= nand_host_pkg::PTR_A;
			stat_mode_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ph_q <= ph_d;
			op_q <= op_d;
			cmd_q <= cmd_d;
			cnt_q <= cnt_d;
			aidx_q <= aidx_d;
			didx_q <= didx_d;
			ridx_q <= ridx_d;
			io_out_q <= io_out_d;
			io_oe_q <= io_oe_d;
			cle_q <= cle_d;
			ale_q <= ale_d;
			we_n_q <= we_n_d;
			re_n_q <= re_n_d;
			ce_n_q <= ce_n_d;
			status_byte_q <= status_byte_d;
			maker_q <= maker_d;
			device_q <= device_d;
			refused_q <= refused_d;
			timeout_q <= timeout_d;
			page_q <= page_d;
			pp_cnt_q <= pp_cnt_d;
			ptr_q <= ptr_d;
			stat_mode_q <= stat_mode_d;
		end
	end

	// Software register port.
	always_comb
	begin
		wp_en_d = wp_en_q;
		addr_d = addr_q;
		wr_ptr_d = wr_ptr_q;
		buf_we = 1'b0;
		rdata_d = 32'h0000_0000;
		if (reg_wr && reg_addr == nand_host_pkg::REG_CFG)
			wp_en_d = reg_wdata[0];
		if (reg_wr && reg_addr == nand_host_pkg::REG_ADDR)
			addr_d = reg_wdata[23:0];
		if (reg_wr && reg_addr == nand_host_pkg::REG_DATA
			&& 32'(wr_ptr_q) < PAGE_DEPTH)
		begin
			buf_we = 1'b1;
			wr_ptr_d = wr_ptr_q + 10'h001;
		end
		if (launch)
			wr_ptr_d = 10'h000;
		if (reg_rd)
		begin
			unique case (reg_addr)
			nand_host_pkg::REG_CFG: rdata_d[0] = wp_en_q;
			nand_host_pkg::REG_ADDR: rdata_d[23:0] = addr_q;
			nand_host_pkg::REG_STAT:
			begin
				rdata_d[7:0] = status_byte_q;
				rdata_d[nand_host_pkg::STAT_BUSY_POS] =
					state_q != nand_host_pkg::ST_IDLE;
				rdata_d[nand_host_pkg::STAT_REFUSED_POS] = refused_q;
				rdata_d[nand_host_pkg::STAT_TIMEOUT_POS] = timeout_q;
				rdata_d[nand_host_pkg::STAT_PP_POS +: 4] = pp_cnt_q;
				rdata_d[nand_host_pkg::STAT_PTR_POS +: 2] = ptr_q;
				rdata_d[nand_host_pkg::STAT_MODE_POS] = stat_mode_q;
				rdata_d[nand_host_pkg::STAT_FILL_POS +: 10] = wr_ptr_q;
			end
			nand_host_pkg::REG_ID: rdata_d[15:0] = {device_q, maker_q};
			default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			wp_en_q <= 1'b0;
			addr_q <= 24'h00_0000;
			wr_ptr_q <= 10'h000;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wp_en_q <= wp_en_d;
			addr_q <= addr_d;
			wr_ptr_q <= wr_ptr_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign io_out = io_out_q;
	assign io_oe = io_oe_q;
	assign cle = cle_q;
	assign ale = ale_q;
	assign ce_n = ce_n_q;
	assign we_n = we_n_q;
	assign re_n = re_n_q;
	assign wp_n = wp_en_q;
endmodule : nand_host

// File: core/nand_host_pkg.sv
// Constants, commands, register map and states of the NAND flash host.
// Assumes a 20 MHz system clock and a byte-wide multiplexed flash bus.
//
// Behaviour
// - At most ten partial programs per page; only the last page programmed is counted.
// - Program: 80H, three addresses, data, 10H.
// - Only intended bytes need loading.
// - Status mode persists; read command resumes reads.
// - Erase: 60H, two addresses, D0H.
// - 90H, address 00H, read maker, device.
// - Low write-protect blocks program and erase.
package nand_host_pkg;
	localparam int CLK_MHZ = 20;
	localparam int T_WB_NS = 100;
	localparam int T_WHR_NS = 60;
	localparam int T_RST_US = 500;
	localparam int WB_CYCLES = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam int WHR_CYCLES = (T_WHR_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_CYCLES = T_RST_US * CLK_MHZ;
	localparam int PAGE_BYTES = 528;
	localparam int PARTIAL_MAX = 10;

	localparam logic [7:0] CMD_READ_A = 8'h00;
	localparam logic [7:0] CMD_READ_B = 8'h01;
	localparam logic [7:0] CMD_READ_C = 8'h50;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] ID_ADDR = 8'h00;

	localparam logic [7:0] STATUS_RESET = 8'hc0;
	localparam int PASS_FAIL_BIT = 0;
	localparam int READY_FLAG_BIT = 6;
	localparam int UNPROTECTED_BIT = 7;

	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CFG = 4'h1;
	localparam logic [3:0] REG_ADDR = 4'h2;
	localparam logic [3:0] REG_DATA = 4'h3;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_ID = 4'h5;

	localparam int STAT_BUSY_POS = 8;
	localparam int STAT_REFUSED_POS = 9;
	localparam int STAT_TIMEOUT_POS = 10;
	localparam int STAT_PP_POS = 11;
	localparam int STAT_PTR_POS = 15;
	localparam int STAT_MODE_POS = 17;
	localparam int STAT_FILL_POS = 20;

	localparam logic [2:0] OP_RESET = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_ERASE = 3'h2;
	localparam logic [2:0] OP_STATUS = 3'h3;
	localparam logic [2:0] OP_ID = 3'h4;
	localparam logic [2:0] OP_PTR_A = 3'h5;
	localparam logic [2:0] OP_PTR_B = 3'h6;
	localparam logic [2:0] OP_PTR_C = 3'h7;

	localparam logic [1:0] PTR_A = 2'h0;
	localparam logic [1:0] PTR_B = 2'h1;
	localparam logic [1:0] PTR_C = 2'h2;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_CMD = 8'h02,
		ST_ADDR = 8'h04,
		ST_DATA = 8'h08,
		ST_WAIT = 8'h10,
		ST_BUSY = 8'h20,
		ST_GAP = 8'h40,
		ST_READ = 8'h80
	} state_type;
endpackage : nand_host_pkg

// File: core/page_buffer.sv
// Program data buffer: one write port, one read port with registered data.
// Assumes the writer never addresses beyond the depth.
`timescale 1ns/10ps
module page_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 528,
	parameter int AW = 10
) (
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_q;
	logic [WIDTH-1:0] rd_data_d;

	if (DEPTH < 1 || DEPTH > (1 << AW))
		$error("page_buffer: depth does not fit the address width");

	// Out-of-range reads return all ones, like an unloaded flash byte.
	always_comb
	begin
		rd_data_d = '1;
		if (32'(rd_addr) < DEPTH)
			rd_data_d = mem[rd_addr];
	end

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_q <= rd_data_d;
	end

	assign rd_data = rd_data_q;
endmodule : page_buffer
